// ==== include/fbi_consts.svh ====
/*
 Timing counts, widths and reset values for the feedback command generator.
 Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef FBI_CONSTS_SVH
`define FBI_CONSTS_SVH

`define FBI_UPDATE_HZ 1500
`define FBI_LAST_SLOT 4'hE
`define FBI_SLOT_RESET 4'hE
`define FBI_EST_W 12
`define FBI_PROD_W 24
`define FBI_SUM_W 26
`define FBI_RESUME_CHIPS 11'h400
`define FBI_CHIP_CNT_W 11
`define FBI_M2_BITS 4
`define FBI_M2_POS_RESET 2'h3
`define FBI_CMD_RESET 1'h0
`define FBI_WORD_RESET 4'h0

`endif

// ==== include/fbi_pkg.sv ====
/*
 Types shared by the feedback command generator files.
 Assumes fbi_consts.svh carries all numeric constants.
*/
package fbi_pkg;

   typedef enum logic {
      mode_one = 1'b0,
      mode_two = 1'b1
   } fb_mode_e;

   typedef enum logic [1:0] {
      rs_live = 2'b00,
      rs_gap = 2'b01,
      rs_count = 2'b10,
      rs_armed = 2'b11
   } resume_state_e;

endpackage

// ==== logic/in_sync3.sv ====
/*
 Three flip-flop input synchroniser with agreement filter.
 Assumes an asynchronous pin level; output is a clean clk-domain level.
*/
module in_sync3 (
   input wire logic clk,       // System clock
   input wire logic rst_b,     // Async reset, active low
   input wire logic pin_in,    // Asynchronous pin level
   output logic level_out      // Filtered synchronous level
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic level_reg;
   wire agree = (s2_reg == s3_reg);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level_reg <= 1'b0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // One-stage glitch is ignored until two stages agree
         if (agree) begin
            level_reg <= s3_reg;
         end
      end
   end

   assign level_out = level_reg;

endmodule

// ==== logic/fb_phase_quant.sv ====
/*
 Combinational phase quantiser for the two-antenna pilot estimates.
 Assumes estimates are signed, stable in the cycle they are sampled.
*/
`include "fbi_consts.svh"

module fb_phase_quant (
   input wire logic signed [`FBI_EST_W-1:0] h1_i,   // Antenna 1 estimate, real
   input wire logic signed [`FBI_EST_W-1:0] h1_q,   // Antenna 1 estimate, imag
   input wire logic signed [`FBI_EST_W-1:0] h2_i,   // Antenna 2 estimate, real
   input wire logic signed [`FBI_EST_W-1:0] h2_q,   // Antenna 2 estimate, imag
   input wire logic odd_slot,                       // Uplink slot index is odd
   output logic m1_cmd,                             // One-slot phase command
   output logic [`FBI_M2_BITS-1:0] m2_word          // Power bit then 3 phase bits
);

   wire signed [`FBI_PROD_W-1:0] p_ii = h1_i * h2_i;
   wire signed [`FBI_PROD_W-1:0] p_qq = h1_q * h2_q;
   wire signed [`FBI_PROD_W-1:0] p_iq = h1_i * h2_q;
   wire signed [`FBI_PROD_W-1:0] p_qi = h1_q * h2_i;
   wire signed [`FBI_PROD_W-1:0] e1_ii = h1_i * h1_i;
   wire signed [`FBI_PROD_W-1:0] e1_qq = h1_q * h1_q;
   wire signed [`FBI_PROD_W-1:0] e2_ii = h2_i * h2_i;
   wire signed [`FBI_PROD_W-1:0] e2_qq = h2_q * h2_q;

   // Cross term conj(h1)*h2; two guard bits keep the negation exact
   wire signed [`FBI_SUM_W-1:0] c_re = {{2{p_ii[`FBI_PROD_W-1]}}, p_ii} + {{2{p_qq[`FBI_PROD_W-1]}}, p_qq};
   wire signed [`FBI_SUM_W-1:0] c_im = {{2{p_iq[`FBI_PROD_W-1]}}, p_iq} - {{2{p_qi[`FBI_PROD_W-1]}}, p_qi};
   wire signed [`FBI_SUM_W-1:0] best_y = -c_im;
   wire signed [`FBI_SUM_W-1:0] ax = c_re[`FBI_SUM_W-1] ? -c_re : c_re;
   wire signed [`FBI_SUM_W-1:0] ay = best_y[`FBI_SUM_W-1] ? -best_y : best_y;
   wire x_neg = c_re[`FBI_SUM_W-1];
   wire y_neg = best_y[`FBI_SUM_W-1];
   wire [1:0] quadrant = {y_neg, x_neg ^ y_neg};
   wire upper_half = quadrant[0] ? (ay <= ax) : (ay >= ax);
   wire [`FBI_SUM_W-1:0] pow1 = {2'h0, e1_ii} + {2'h0, e1_qq};
   wire [`FBI_SUM_W-1:0] pow2 = {2'h0, e2_ii} + {2'h0, e2_qq};

   // Odd slots see antenna 2 turned a quarter: Re(j*c) = -Im(c)
   wire rot_neg = odd_slot ? (c_im > 0) : x_neg;
   // Phase zero for the half plane around zero, else pi
   assign m1_cmd = rot_neg;
   // Mode 2 has no rotation; octant of the best phase
   assign m2_word = {pow1 >= pow2, quadrant, upper_half};
endmodule

// ==== logic/fbi_ue_ctrl.sv ====
/*
 UE-side closed loop feedback command generator, driving one FBI D bit per non-idle
 uplink slot. Assumes slot and chip strobes from the same clock domain and a
 downlink activity pin that is asynchronous.
*/
`include "fbi_consts.svh"

// What this block does
// - Mode 1: one phase bit per slot
// - Mode 2: four-slot word, power plus phase
// - Word bits go out MSB first
// - Compute phase adjustment every slot
// - Odd slots rotate antenna 2 a quarter
// - Quantize to zero or pi, send 0/1
// - First frame uses the normal procedure
// - No estimate: resend command of slot i-2; slots 0 and 1 resend slots 14 and 13
// - Resume: first new command after 1024 chips
// - Uplink idle slots carry no command
module fbi_ue_ctrl (
   input wire logic clk,                            // 100 MHz clock
   input wire logic rst_b,                          // Async reset, active low
   input wire logic mode_sel,                       // 0 = mode 1, 1 = mode 2
   input wire logic slot_strobe,                    // Uplink slot start pulse
   input wire logic frame_start,                    // With slot_strobe: slot 0
   input wire logic chip_tick,                      // One pulse per chip
   input wire logic est_valid,                      // Fresh estimate this slot
   input wire logic signed [`FBI_EST_W-1:0] h1_i,   // Antenna 1 estimate, real
   input wire logic signed [`FBI_EST_W-1:0] h1_q,   // Antenna 1 estimate, imag
   input wire logic signed [`FBI_EST_W-1:0] h2_i,   // Antenna 2 estimate, real
   input wire logic signed [`FBI_EST_W-1:0] h2_q,   // Antenna 2 estimate, imag
   input wire logic ul_idle,                        // Uplink slot is a gap slot
   input wire logic dl_on_pin,                      // Downlink active, async pin
   output logic fbi_d,                              // Feedback bit for the slot
   output logic fbi_valid,                          // Pulse: fbi_d is sent
   output logic [3:0] slot_idx                      // Current uplink slot
);

   fbi_pkg::resume_state_e rs_reg;
   fbi_pkg::resume_state_e rs_next;
   logic [3:0] slot_reg;
   logic [1:0] pos_reg;
   logic [`FBI_M2_BITS-1:0] word_reg;
   logic [`FBI_CHIP_CNT_W-1:0] chip_cnt_reg;
   logic [14:0] hist_reg;
   logic fbi_d_reg;
   logic fbi_valid_reg;
   logic dl_on;
   logic dl_on_d_reg;
   logic q_m1_cmd;
   logic [`FBI_M2_BITS-1:0] q_m2_word;

   in_sync3 u_dl_sync (
      .clk(clk),
      .rst_b(rst_b),
      .pin_in(dl_on_pin),
      .level_out(dl_on)
   );

   // Slot counter wraps after the last slot; frame_start forces slot 0
   wire slot_wrap = (slot_reg == `FBI_LAST_SLOT);
   wire [3:0] slot_inc = slot_reg + 4'h1;
   wire [3:0] cur_slot = frame_start ? 4'h0 : (slot_wrap ? 4'h0 : slot_inc);
   wire [3:0] slot_back = 4'hE - cur_slot;
   wire [3:0] slot_minus2 = cur_slot - 4'h2;
   // Slot 0 reuses slot 14, slot 1 reuses slot 13 of the last frame
   wire [3:0] resend_idx = (cur_slot < 4'h2) ? slot_back : slot_minus2;

   fb_phase_quant u_quant (
      .h1_i(h1_i),
      .h1_q(h1_q),
      .h2_i(h2_i),
      .h2_q(h2_q),
      .odd_slot(cur_slot[0]),
      .m1_cmd(q_m1_cmd),
      .m2_word(q_m2_word)
   );

   wire mode2 = (mode_sel == fbi_pkg::mode_two);
   wire dl_rise = dl_on && !dl_on_d_reg;
   wire chips_done = chip_tick && (chip_cnt_reg == `FBI_RESUME_CHIPS - 11'h1);
   // Estimates are trusted only while the downlink is live or just rearmed
   wire est_ok = (rs_reg == fbi_pkg::rs_live) || (rs_reg == fbi_pkg::rs_armed);
   wire use_new = est_valid && est_ok;
   wire send_now = slot_strobe && !ul_idle;
   // First frame runs the same path: history simply starts at zero
   wire m1_bit = use_new ? q_m1_cmd : hist_reg[resend_idx];

   wire [1:0] pos_inc = pos_reg + 2'h1;
   wire [1:0] cur_pos = frame_start ? 2'h0 : pos_inc;
   wire word_start = (cur_pos == 2'h0);
   // Word is latched at its first slot and kept if no estimate is ready
   wire [`FBI_M2_BITS-1:0] cur_word = word_start ? (use_new ? q_m2_word : word_reg) : word_reg;
   wire [1:0] bit_sel = 2'h3 - cur_pos;
   wire m2_bit = cur_word[bit_sel];
   wire tx_bit = mode2 ? m2_bit : m1_bit;

   // Resume sequencing: gap, then 1024 chips, then the next uplink slot
   always_comb begin
      rs_next = rs_reg;
      case (rs_reg)
         fbi_pkg::rs_live: begin
            if (!dl_on) begin
               rs_next = fbi_pkg::rs_gap;
            end
         end
         fbi_pkg::rs_gap: begin
            if (dl_rise) begin
               rs_next = fbi_pkg::rs_count;
            end
         end
         fbi_pkg::rs_count: begin
            if (!dl_on) begin
               rs_next = fbi_pkg::rs_gap;
            end else if (chips_done) begin
               rs_next = fbi_pkg::rs_armed;
            end
         end
         fbi_pkg::rs_armed: begin
            if (!dl_on) begin
               rs_next = fbi_pkg::rs_gap;
            end else if (slot_strobe) begin
               rs_next = fbi_pkg::rs_live;
            end
         end
         default: begin
            rs_next = fbi_pkg::rs_gap;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rs_reg <= fbi_pkg::rs_live;
         dl_on_d_reg <= 1'b1;
         chip_cnt_reg <= '0;
      end else begin
         rs_reg <= rs_next;
         dl_on_d_reg <= dl_on;
         if (rs_reg != fbi_pkg::rs_count) begin
            chip_cnt_reg <= '0;
         end else if (chip_tick) begin
            chip_cnt_reg <= chip_cnt_reg + 11'h1;
         end
      end
   end

   // Slot and word position advance even in idle slots to keep alignment
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         slot_reg <= `FBI_SLOT_RESET;
         pos_reg <= `FBI_M2_POS_RESET;
         word_reg <= `FBI_WORD_RESET;
      end else if (slot_strobe) begin
         slot_reg <= cur_slot;
         pos_reg <= cur_pos;
         word_reg <= cur_word;
      end
   end

   // Per-slot history of sent mode 1 commands, for resending
   genvar k;
   generate
      for (k = 0; k < 15; k = k + 1) begin : g_hist
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               hist_reg[k] <= `FBI_CMD_RESET;
            end else if (send_now && !mode2 && (cur_slot == k)) begin
               hist_reg[k] <= m1_bit;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fbi_d_reg <= 1'b0;
         fbi_valid_reg <= 1'b0;
      end else begin
         fbi_valid_reg <= send_now;
         if (send_now) begin
            fbi_d_reg <= tx_bit;
         end
      end
   end

   assign fbi_d = fbi_d_reg;
   assign fbi_valid = fbi_valid_reg;
   assign slot_idx = slot_reg;

endmodule

// ==== verif/fbi_ue_ctrl_monitor.sv ====
/*
 Port checker for the feedback command generator.
 Assumes bind to fbi_ue_ctrl and slot strobes at least two cycles apart.
*/
module fbi_ue_ctrl_monitor (
   input wire logic clk, // Clock
   input wire logic rst_b, // Reset, low
   input wire logic mode_sel, // Mode
   input wire logic slot_strobe, // Slot start
   input wire logic frame_start, // Slot 0 mark
   input wire logic est_valid, // Fresh estimate
   input wire logic ul_idle, // Gap slot
   input wire logic fbi_d, // Feedback bit
   input wire logic fbi_valid, // Bit sent
   input wire logic [3:0] slot_idx // Slot index
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [14:0] sent_reg;
   logic [3:0] resend_idx;
   logic resend_bit;
   // Index of the slot two back from the coming one; for coming slots 0 and 1 it is 14 and 13
   assign resend_idx = (slot_idx == 4'hE) ? 4'hE : ((slot_idx == 4'h0) ? 4'hD : slot_idx - 4'h1);
   assign resend_bit = sent_reg[resend_idx];
   // Mode 2 words never enter the mode 1 history
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sent_reg <= 15'h0000;
      end else if (fbi_valid && !mode_sel) begin
         sent_reg[slot_idx] <= fbi_d;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_take; slot_strobe && !ul_idle; endsequence
   sequence s_skip; slot_strobe && ul_idle; endsequence
   sequence s_resend; s_take ##0 (!est_valid && !mode_sel && slot_idx <= 4'hE); endsequence
   chk_take_answer: assert property (s_take |=> fbi_valid)
      else $error("no bit after live slot");
   chk_idle_silent: assert property (s_skip |=> !fbi_valid)
      else $error("bit sent in idle slot");
   chk_pulse_once: assert property (fbi_valid |=> !fbi_valid)
      else $error("valid longer than one cycle");
   chk_cause_strobe: assert property (fbi_valid |-> $past(slot_strobe))
      else $error("valid without slot strobe");
   chk_frame_zero: assert property (slot_strobe && frame_start |=> slot_idx == 4'h0)
      else $error("frame start not slot 0");
   chk_slot_step: assert property (slot_strobe && !frame_start && slot_idx < 4'hE |=> slot_idx == $past(slot_idx) + 4'h1)
      else $error("slot index did not advance");
   chk_bit_holds: assert property (!fbi_valid |-> $stable(fbi_d))
      else $error("bit changed outside a send");
   chk_resend_bit: assert property (s_resend |=> fbi_d == $past(resend_bit))
      else $error("resent bit differs");
endmodule

bind fbi_ue_ctrl fbi_ue_ctrl_monitor u_fbi_ue_ctrl_monitor (.clk(clk), .rst_b(rst_b), .mode_sel(mode_sel),
   .slot_strobe(slot_strobe), .frame_start(frame_start), .est_valid(est_valid), .ul_idle(ul_idle),
   .fbi_d(fbi_d), .fbi_valid(fbi_valid), .slot_idx(slot_idx));

// ==== verif/ap_weight_model.sv ====
/*
 Behavioural access point: mode 1 phase mapping and antenna weights.
 Assumes commands arrive as fbi_d with fbi_valid and slot_idx.
*/
module ap_weight_model (
   input wire logic clk, // Clock
   input wire logic rst_b, // Reset, low
   input wire logic fbi_d, // Command
   input wire logic fbi_valid, // Command arrives
   input wire logic [3:0] slot_idx, // Uplink slot
   output int w2_re, // Weight 2 real, times root two
   output int w2_im, // Weight 2 imag, times root two
   output int w1 // Weight 1
);
   timeunit 1ns;
   timeprecision 1ps;
   int ph[15];
   int cs[4] = '{1, 0, -1, 0};
   int sn[4] = '{0, 1, 0, -1};
   int i, j, p, last_j;
   assign w1 = 1;
   // Weights only move on a received command, so gaps hold them
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         last_j = -1;
         w2_re = 0;
         w2_im = 0;
      end else if (fbi_valid === 1'b1) begin
         i = slot_idx;
         p = fbi_d ? (i % 2 ? 3 : 2) : i % 2;
         j = last_j;
         if (j < 0) begin
            w2_re = cs[p];
            w2_im = sn[p] + 1;
         end else begin
            while (j % 2 == i % 2) j = (j == 0) ? 14 : j - 1;
            w2_re = cs[p] + cs[ph[j]];
            w2_im = sn[p] + sn[ph[j]];
         end
         ph[i] = p;
         last_j = i;
      end
   end
endmodule

// ==== verif/closed_loop_tx_diversity_weights_tb_top.sv ====
/*
 Self-checking bench for fbi_ue_ctrl with an access point model.
 Assumes chip ticks every second cycle, so resume counts take ~2048 cycles.
*/
module closed_loop_tx_diversity_weights_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic mode_sel = 1'b0, slot_strobe = 1'b0, frame_start = 1'b0, chip_tick = 1'b0;
   logic est_valid = 1'b0, ul_idle = 1'b0, dl_on_pin = 1'b1, mode_want = 1'b0, cmd;
   logic signed [11:0] h1_i = 12'h000, h1_q = 12'h000, h2_i = 12'h000, h2_q = 12'h000;
   logic fbi_d, fbi_valid;
   logic [3:0] slot_idx, word;
   logic hist[15];
   logic [4:0] notes[$];
   int w2_re, w2_im, w1, re, im;
   int failures = 0, comparisons = 0, slot_n = 14, armed = 0;
   int seed = 32'h4423;
   fbi_ue_ctrl u_fbi_ue_ctrl (.clk(clk), .rst_b(rst_b), .mode_sel(mode_sel), .slot_strobe(slot_strobe),
      .frame_start(frame_start), .chip_tick(chip_tick), .est_valid(est_valid), .h1_i(h1_i), .h1_q(h1_q),
      .h2_i(h2_i), .h2_q(h2_q), .ul_idle(ul_idle), .dl_on_pin(dl_on_pin), .fbi_d(fbi_d),
      .fbi_valid(fbi_valid), .slot_idx(slot_idx));
   ap_weight_model u_ap_weight_model (.clk(clk), .rst_b(rst_b), .fbi_d(fbi_d), .fbi_valid(fbi_valid),
      .slot_idx(slot_idx), .w2_re(w2_re), .w2_im(w2_im), .w1(w1));
   always #5 clk = ~clk;
   always @(negedge clk) chip_tick <= ~chip_tick;
   task automatic check(input logic [4:0] got, input logic [4:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic slot_go(input logic ev, input logic idle);
      @(negedge clk);
      slot_n = (slot_n == 14) ? 0 : slot_n + 1;
      if (slot_n == 0) mode_sel = mode_want;
      if (!mode_want) begin
         h1_i = 12'($random(seed));
         h1_q = 12'($random(seed));
         h2_i = 12'($random(seed));
         h2_q = 12'($random(seed));
      end
      re = h1_i * h2_i + h1_q * h2_q;
      im = h1_i * h2_q - h1_q * h2_i;
      if (mode_sel) cmd = word[3 - slot_n % 4];
      else if (ev && armed) cmd = (slot_n % 2) ? (im > 0) : (re < 0);
      else cmd = hist[slot_n == 0 ? 14 : slot_n == 1 ? 13 : slot_n - 2];
      if (!idle) begin
         if (!mode_sel) hist[slot_n] = cmd;
         notes.push_back({4'(slot_n), cmd});
      end
      slot_strobe = 1'b1;
      frame_start = (slot_n == 0);
      est_valid = ev;
      ul_idle = idle;
      @(negedge clk);
      slot_strobe = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   // Pop one note per sent bit; an extra bit shows as a mismatch
   // Looked at on the falling edge, where the registered outputs have settled
   always @(negedge clk) begin
      if (fbi_valid === 1'b1) begin
         if (notes.size() == 0) check({slot_idx, fbi_d}, 5'h1F);
         else check({slot_idx, fbi_d}, notes.pop_front());
      end
   end
   initial begin
      foreach (hist[k]) hist[k] = 1'b0;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      repeat (2100) @(negedge clk);
      armed = 1;
      repeat (30) slot_go(1'b1, 1'b0);
      repeat (30) slot_go(1'($random(seed)), $random(seed) % 4 == 0);
      repeat (15) slot_go(1'b0, 1'b0);
      dl_on_pin = 1'b0;
      armed = 0;
      repeat (10) @(negedge clk);
      repeat (3) slot_go(1'b1, 1'b0);
      dl_on_pin = 1'b1;
      repeat (10) @(negedge clk);
      repeat (3) slot_go(1'b1, 1'b0);
      repeat (2100) @(negedge clk);
      armed = 1;
      while (slot_n != 14) slot_go(1'b1, 1'b0);
      mode_want = 1'b1;
      for (int k = 0; k < 2; k++) begin
         h1_i = 12'h100;
         h1_q = 12'h000;
         h2_i = k ? 12'h200 : 12'h080;
         h2_q = 12'h000;
         word = {k == 0, 3'h0};
         repeat (15) slot_go(1'b1, 1'b0);
      end
      repeat (5) @(negedge clk);
      check(5'(notes.size()), 5'h00);
      close_out();
   end
   initial begin
      #200000;
      failures++;
      close_out();
   end
endmodule
